/* File: shared/osrt_defs.vh */
// Constants for the oscillator select and start-up reset timers
`ifndef OSRT_DEFS_VH
`define OSRT_DEFS_VH

// Clock
`define OSRT_CLK_MHZ 200

// Fuse locations in configuration space
`define OSRT_FUSE_LO_ADDR 16'hFE00
`define OSRT_FUSE_HI_ADDR 16'hFE01
`define OSRT_PM_AW 16

// Oscillator select codes
`define OSRT_MODE_LOW_FREQ_XTAL 2'h0
`define OSRT_MODE_RC_OSC 2'h1
`define OSRT_MODE_XTAL 2'h2
`define OSRT_MODE_EXT_CLOCK 2'h3

// Timers
`define OSRT_TMR_W 10
`define OSRT_OST_PERIODS 1024
`define OSRT_POWERUP_DELAY_TIMER_STAGES 1024
`define OSRT_POWERUP_DELAY_TIMER_TIME_MS 80
`define OSRT_POWERUP_DELAY_TIMER_TICK_CYC (`OSRT_POWERUP_DELAY_TIMER_TIME_MS * 1000 * `OSRT_CLK_MHZ / `OSRT_POWERUP_DELAY_TIMER_STAGES)
`define OSRT_TICK_W 24

// Register offsets
`define OSRT_REG_CTRL 8'h00
`define OSRT_REG_STATUS 8'h04
`define OSRT_REG_OST_CNT 8'h08
`define OSRT_REG_POWERUP_DELAY_TIMER_CNT 8'h0C

// Field positions and reset values
`define OSRT_CTRL_QUARTER_CLOCK_OUT_EN 0
`define OSRT_CTRL_RESET 32'h0000_0001
`define OSRT_ST_MODE_LO 0
`define OSRT_ST_OST_BUSY 2
`define OSRT_ST_POWERUP_DELAY_TIMER_BUSY 3
`define OSRT_ST_CORE_RST 4
`define OSRT_ST_MODE_VALID 5
`define OSRT_ST_POWERUP_DELAY_TIMER_DONE 6

`endif

/* File: core/osrt_top.v */
// Oscillator mode select, start-up timers and core reset sequencing
//
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/10ps
//
// Behaviour
// RQ1: Read high select fuse at FE01h and low select fuse at FE00h.
// RQ2: Programmed fuse reads as zero, unprogrammed fuse as one.
// RQ3: Code 11 is external clock; second pin drives quarter clock.
// RQ4: Code 01 is RC oscillator; second pin drives quarter clock.
// RQ5: Code 10 is crystal mode; second pin carries no clock output.
// RQ6: Code 00 is low frequency crystal, handled like crystal mode.
// RQ7: Start-up timer holds reset 1024 oscillator periods on power-up and wake.
// RQ8: Start-up delay is a 10-bit counter clocked by first pin.
// RQ9: Power-up start-up count begins at master reset rising edge.
// RQ10: Wake-up start-up count begins at the wake event.
// RQ11: Start-up counter waits until oscillator amplitude is detectable.
// RQ12: Core stays in reset until start-up count completes.
// RQ13: Start-up delay skipped in RC and external clock modes.
// RQ14: Power-up timer gives about 80 ms, power-up only, not on wake.
// RQ15: Power-up delay is 10-bit counter clocked by on-chip RC oscillator.
// RQ16: Power-up timer starts at master reset rising edge.
// RQ17: Power-on reset pulse resets internal registers to defined values.
// RQ18: No internal reset generated when supply falls.
// RQ19: Both timers start together; crystal modes wait for the longer.
// RQ20: Reset stays asserted while master reset input is low.
// RQ21: After master reset high, reset held while either timer counts.
// RQ22: RC or external clock wake releases core with no delay.
// RQ23: Decoded mode is latched at reset before timers start.
`include "osrt_defs.vh"

module osrt_top #(
    parameter [`OSRT_TICK_W-1:0] POWERUP_DELAY_TIMER_TICK_CYC = `OSRT_POWERUP_DELAY_TIMER_TICK_CYC
) (
    // Clock and power-on reset
    input wire SYS_CLK,
    input wire RSTN,
    // AHB-Lite slave
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output wire HREADYOUT,
    output wire HRESP,
    output reg [31:0] HRDATA,
    // Configuration fuse read port
    output reg [`OSRT_PM_AW-1:0] PM_ADDR,
    output reg PM_RD,
    input wire PM_FUSE_BIT,
    // Oscillator pins
    input wire OSC_IN_PIN,
    input wire OSC_AMPL_OK,
    output reg OSC_OUT_PIN_O,
    output reg OSC_OUT_PIN_OE,
    // Master reset pin and wake
    input wire MASTER_RESET_N,
    input wire WAKE_EVENT,
    // Core reset
    output reg CORE_RESET_N
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers, three stages, filtered on agreement
localparam NSYNC = 3;
wire [NSYNC-1:0] pin_in;
reg [NSYNC-1:0] s1_r;
reg [NSYNC-1:0] s2_r;
reg [NSYNC-1:0] s3_r;
reg [NSYNC-1:0] filt_r;
assign pin_in = {OSC_AMPL_OK, MASTER_RESET_N, OSC_IN_PIN};

genvar gi;
generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
        always @(posedge SYS_CLK or negedge RSTN) begin
            if (!RSTN) begin
                s1_r[gi] <= 1'b0;
                s2_r[gi] <= 1'b0;
                s3_r[gi] <= 1'b0;
                filt_r[gi] <= 1'b0;
            end else begin
                s1_r[gi] <= pin_in[gi];
                s2_r[gi] <= s1_r[gi];
                s3_r[gi] <= s2_r[gi];
                if (s2_r[gi] == s3_r[gi]) begin
                    filt_r[gi] <= s3_r[gi];
                end
            end
        end
    end
endgenerate

wire osc_lvl = filt_r[0];
wire master_reset_n_n_lvl = filt_r[1];
wire ampl_ok = filt_r[2];
reg osc_prev_r;
wire osc_rise = osc_lvl & ~osc_prev_r;

////////////////////////////////////////////////////////////////////////////////
// Sequencer states
localparam [6:0] ST_FUSE_LO = 7'h01;
localparam [6:0] ST_FUSE_HI = 7'h02;
localparam [6:0] ST_LATCH = 7'h04;
localparam [6:0] ST_MASTER_RESET_N = 7'h08;
localparam [6:0] ST_COUNT = 7'h10;
localparam [6:0] ST_RUN = 7'h20;
localparam [6:0] ST_WAKE = 7'h40;

reg [6:0] state_r;
reg [6:0] state_nxt;
reg [1:0] mode_r;
reg mode_valid_r;
reg fuse_lo_r;
reg powerup_delay_timer_done_r;
reg ost_done_r;
reg [`OSRT_TMR_W-1:0] ost_cnt_r;
reg [`OSRT_TMR_W-1:0] powerup_delay_timer_cnt_r;
reg [`OSRT_TICK_W-1:0] rc_div_r;
reg [1:0] qdiv_r;
reg [31:0] ctrl_r;

wire xtal_mode = (mode_r == `OSRT_MODE_XTAL) | (mode_r == `OSRT_MODE_LOW_FREQ_XTAL); // RQ5 RQ6
wire ost_run = ((state_r == ST_COUNT) | (state_r == ST_WAKE)) & xtal_mode & ~ost_done_r;
wire powerup_delay_timer_run = (state_r == ST_COUNT) & ~powerup_delay_timer_done_r;
wire rc_tick = (rc_div_r == POWERUP_DELAY_TIMER_TICK_CYC - 1'b1);
wire ost_last = (ost_cnt_r == `OSRT_OST_PERIODS - 1);
wire powerup_delay_timer_last = (powerup_delay_timer_cnt_r == `OSRT_POWERUP_DELAY_TIMER_STAGES - 1);
wire ost_ok = ost_done_r | ~xtal_mode; // RQ13
wire count_done = powerup_delay_timer_done_r & ost_ok; // RQ19 RQ21

////////////////////////////////////////////////////////////////////////////////
// Next state
always @* begin
    state_nxt = state_r;
    case (state_r)
        ST_FUSE_LO: state_nxt = ST_FUSE_HI;
        ST_FUSE_HI: state_nxt = ST_LATCH;
        ST_LATCH: state_nxt = ST_MASTER_RESET_N;
        ST_MASTER_RESET_N: begin
            if (master_reset_n_n_lvl) begin
                state_nxt = ST_COUNT; // RQ9 RQ16
            end
        end
        ST_COUNT: begin
            if (!master_reset_n_n_lvl) begin
                state_nxt = ST_MASTER_RESET_N; // RQ20
            end else if (count_done) begin
                state_nxt = ST_RUN; // RQ21
            end
        end
        ST_RUN: begin
            if (!master_reset_n_n_lvl) begin
                state_nxt = ST_MASTER_RESET_N; // RQ20
            end else if (WAKE_EVENT && xtal_mode) begin
                state_nxt = ST_WAKE; // RQ10
            end
        end
        ST_WAKE: begin
            if (!master_reset_n_n_lvl) begin
                state_nxt = ST_MASTER_RESET_N; // RQ20
            end else if (ost_done_r) begin
                state_nxt = ST_RUN; // RQ7
            end
        end
        default: state_nxt = ST_FUSE_LO;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Sequencer, fuse read and mode latch
always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
        state_r <= ST_FUSE_LO; // RQ17
        mode_r <= `OSRT_MODE_EXT_CLOCK;
        mode_valid_r <= 1'b0;
        fuse_lo_r <= 1'b1;
        PM_ADDR <= `OSRT_FUSE_LO_ADDR;
        PM_RD <= 1'b0;
        CORE_RESET_N <= 1'b0;
    end else begin
        state_r <= state_nxt;
        PM_RD <= 1'b0;
        if (state_r == ST_FUSE_LO) begin
            PM_ADDR <= `OSRT_FUSE_LO_ADDR; // RQ1
            PM_RD <= 1'b1;
        end
        if (state_r == ST_FUSE_HI) begin
            fuse_lo_r <= PM_FUSE_BIT; // RQ1
            PM_ADDR <= `OSRT_FUSE_HI_ADDR; // RQ1
            PM_RD <= 1'b1;
        end
        if (state_r == ST_LATCH) begin
            mode_r <= {PM_FUSE_BIT, fuse_lo_r}; // RQ2 RQ23
            mode_valid_r <= 1'b1; // RQ23
        end
        CORE_RESET_N <= (state_nxt == ST_RUN); // RQ12 RQ20 RQ22
    end
end

////////////////////////////////////////////////////////////////////////////////
// Start-up timer on oscillator edges
always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
        osc_prev_r <= 1'b0;
        ost_cnt_r <= {`OSRT_TMR_W{1'b0}};
        ost_done_r <= 1'b0;
    end else begin
        osc_prev_r <= osc_lvl;
        if ((state_r == ST_MASTER_RESET_N) || (state_r == ST_RUN && WAKE_EVENT)) begin
            ost_cnt_r <= {`OSRT_TMR_W{1'b0}}; // RQ9 RQ10
            ost_done_r <= 1'b0;
        end else if (ost_run && ampl_ok && osc_rise) begin // RQ8 RQ11
            ost_cnt_r <= ost_cnt_r + 1'b1;
            if (ost_last) begin
                ost_done_r <= 1'b1; // RQ7
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Power-up timer on internal RC oscillator ticks
always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
        rc_div_r <= {`OSRT_TICK_W{1'b0}};
        powerup_delay_timer_cnt_r <= {`OSRT_TMR_W{1'b0}};
        powerup_delay_timer_done_r <= 1'b0;
    end else begin
        rc_div_r <= rc_tick ? {`OSRT_TICK_W{1'b0}} : rc_div_r + 1'b1; // RQ15
        if (state_r == ST_MASTER_RESET_N && !powerup_delay_timer_done_r) begin
            powerup_delay_timer_cnt_r <= {`OSRT_TMR_W{1'b0}}; // RQ16
        end else if (powerup_delay_timer_run && rc_tick) begin // RQ14 RQ15
            powerup_delay_timer_cnt_r <= powerup_delay_timer_cnt_r + 1'b1;
            if (powerup_delay_timer_last) begin
                powerup_delay_timer_done_r <= 1'b1; // RQ14
            end
        end
    end
end

// Supply fall makes no reset here; only RSTN low resets. RQ18

////////////////////////////////////////////////////////////////////////////////
// Quarter frequency clock output
always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
        qdiv_r <= 2'h0;
        OSC_OUT_PIN_O <= 1'b0;
        OSC_OUT_PIN_OE <= 1'b0;
    end else begin
        if (osc_rise) begin
            qdiv_r <= qdiv_r + 1'b1;
        end
        OSC_OUT_PIN_O <= qdiv_r[1] & ~xtal_mode & ctrl_r[`OSRT_CTRL_QUARTER_CLOCK_OUT_EN]; // RQ3 RQ4
        OSC_OUT_PIN_OE <= mode_valid_r & ~xtal_mode; // RQ3 RQ4 RQ5
    end
end

////////////////////////////////////////////////////////////////////////////////
// AHB-Lite register slave, zero wait states
reg wr_pend_r;
reg [7:0] wr_addr_r;
wire addr_ok = HSEL & HTRANS[1] & HREADY;
wire [31:0] status_w = {25'h000_0000, powerup_delay_timer_done_r, mode_valid_r, ~CORE_RESET_N,
    powerup_delay_timer_run, ost_run, mode_r};

assign HREADYOUT = 1'b1;
assign HRESP = 1'b0;

always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
        wr_pend_r <= 1'b0;
        wr_addr_r <= 8'h00;
        ctrl_r <= `OSRT_CTRL_RESET;
        HRDATA <= 32'h0000_0000;
    end else begin
        wr_pend_r <= addr_ok & HWRITE;
        if (addr_ok) begin
            wr_addr_r <= HADDR[7:0];
        end
        if (wr_pend_r && wr_addr_r == `OSRT_REG_CTRL) begin
            ctrl_r <= {31'h0000_0000, HWDATA[`OSRT_CTRL_QUARTER_CLOCK_OUT_EN]};
        end
        if (addr_ok && !HWRITE) begin
            case (HADDR[7:0])
                `OSRT_REG_CTRL: HRDATA <= ctrl_r;
                `OSRT_REG_STATUS: HRDATA <= status_w;
                `OSRT_REG_OST_CNT: HRDATA <= {22'h00_0000, ost_cnt_r};
                `OSRT_REG_POWERUP_DELAY_TIMER_CNT: HRDATA <= {22'h00_0000, powerup_delay_timer_cnt_r};
                default: HRDATA <= 32'h0000_0000;
            endcase
        end
    end
end

endmodule // osrt_top

/* File: testbench/osrt_assertions.sv */
// Checker for fuse reads, second pin drive and core reset release
`timescale 1ns/10ps
`include "osrt_defs.vh"
module osrt_assertions #(
    parameter [`OSRT_TICK_W-1:0] POWERUP_DELAY_TIMER_TICK_CYC = `OSRT_POWERUP_DELAY_TIMER_TICK_CYC
) (
    // Clock and reset
    input wire SYS_CLK,
    input wire RSTN,
    // Fuse port
    input wire [`OSRT_PM_AW-1:0] PM_ADDR,
    input wire PM_RD,
    input wire PM_FUSE_BIT,
    // Pins and core reset
    input wire OSC_IN_PIN,
    input wire OSC_OUT_PIN_OE,
    input wire MASTER_RESET_N,
    input wire WAKE_EVENT,
    input wire CORE_RESET_N
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    reg mode_lo_r;
    reg osc_r;
    reg [15:0] hi_cnt_r;
    reg [11:0] edge_cnt_r;
    ////////////////////////////////////////////////////////////////
    // Mode shadow and hold counters
    always @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            mode_lo_r <= 1'b0;
            osc_r <= 1'b0;
            hi_cnt_r <= 16'h0000;
            edge_cnt_r <= 12'h000;
        end else begin
            if (PM_RD && PM_ADDR == `OSRT_FUSE_LO_ADDR) begin
                mode_lo_r <= PM_FUSE_BIT;
            end
            osc_r <= OSC_IN_PIN;
            hi_cnt_r <= CORE_RESET_N ? 16'h0000 : hi_cnt_r + {15'h0000, MASTER_RESET_N};
            edge_cnt_r <= CORE_RESET_N ? 12'h000 : edge_cnt_r + {11'h000, MASTER_RESET_N && OSC_IN_PIN && !osc_r};
        end
    end
    ////////////////////////////////////////////////////////////////
    // Assertions
    a_fuse_order: assert property (PM_RD && PM_ADDR == 16'hFE00 |=> PM_RD && PM_ADDR == 16'hFE01)
        else $error("fuse reads out of order");
    a_fuse_once: assert property (PM_RD && PM_ADDR == 16'hFE01 |=> !PM_RD [*8])
        else $error("fuse read repeated");
    a_master_reset_n_holds: assert property (!MASTER_RESET_N [*8] |-> !CORE_RESET_N)
        else $error("core out of reset under master reset");
    a_clk_pin_on: assert property (CORE_RESET_N && mode_lo_r |-> OSC_OUT_PIN_OE)
        else $error("second pin not driven");
    a_clk_pin_off: assert property (CORE_RESET_N && !mode_lo_r |-> !OSC_OUT_PIN_OE)
        else $error("second pin driven in crystal mode");
    a_wake_ignored: assert property (WAKE_EVENT && CORE_RESET_N && MASTER_RESET_N && mode_lo_r
        |=> CORE_RESET_N [*4])
        else $error("wake reset in rc or clock mode");
    a_wake_holds: assert property (WAKE_EVENT && CORE_RESET_N && MASTER_RESET_N && !mode_lo_r
        |=> !CORE_RESET_N)
        else $error("crystal wake without reset");
    a_powerup_delay_timer_span: assert property ($rose(CORE_RESET_N) |-> hi_cnt_r >= 1024 * POWERUP_DELAY_TIMER_TICK_CYC)
        else $error("core released before power-up delay");
    a_ost_span: assert property ($rose(CORE_RESET_N) && !mode_lo_r |-> edge_cnt_r >= 1024)
        else $error("core released before start-up count");
endmodule // osrt_assertions

bind osrt_top osrt_assertions #(.POWERUP_DELAY_TIMER_TICK_CYC(POWERUP_DELAY_TIMER_TICK_CYC)) u_chk (.SYS_CLK(SYS_CLK), .RSTN(RSTN),
    .PM_ADDR(PM_ADDR), .PM_RD(PM_RD), .PM_FUSE_BIT(PM_FUSE_BIT), .OSC_IN_PIN(OSC_IN_PIN),
    .OSC_OUT_PIN_OE(OSC_OUT_PIN_OE), .MASTER_RESET_N(MASTER_RESET_N), .WAKE_EVENT(WAKE_EVENT),
    .CORE_RESET_N(CORE_RESET_N));

/* File: testbench/osrt_osc_model.sv */
// Model of the oscillator source and configuration fuses
`timescale 1ns/10ps
module osrt_osc_model (
    // Clock and controls
    input wire logic clk,
    input wire logic run,
    input wire logic [1:0] code,
    // Fuse port
    input wire logic [15:0] pm_addr,
    input wire logic pm_rd,
    output logic fuse_bit,
    // Oscillator pin
    output logic osc = 1'b0,
    output logic ampl_ok = 1'b0
);
    int ph = 0;
    int amp = 0;
    // Fuse answers in the cycle of the read strobe
    always @* begin
        if (pm_rd && pm_addr == 16'hFE01) begin
            fuse_bit = code[1];
        end else if (pm_rd && pm_addr == 16'hFE00) begin
            fuse_bit = code[0];
        end else begin
            fuse_bit = ~code[0];
        end
    end
    always @(posedge clk) begin
        ph <= run ? (ph + 1) % 6 : 0;
        osc <= run && ph >= 3;
        amp <= run ? amp + 1 : 0;
        ampl_ok <= run && amp >= 200;
    end
endmodule // osrt_osc_model

/* File: testbench/osrt_top_bench.sv */
// Self-checking bench for mode select and reset release
`timescale 1ns/10ps
module osrt_top_bench;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic master_reset_n_n = 1'b0;
    logic wake = 1'b0;
    logic osc_run = 1'b0;
    logic [1:0] code = 2'h0;
    logic [1:0] mcodes [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
    logic [31:0] rd;
    logic qo;
    logic xtal;
    wire hreadyout, hresp, pm_rd, osc_in, ampl_ok, fuse_bit, osc_o, osc_oe, core_n;
    wire [31:0] hrdata;
    wire [15:0] pm_addr;
    int n_mismatch = 0;
    int checks = 0;
    int n;
    int q;
    always #2.5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////
    osrt_top #(.POWERUP_DELAY_TIMER_TICK_CYC(24'h00_0004)) dut (.SYS_CLK(sys_clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata), .PM_ADDR(pm_addr), .PM_RD(pm_rd),
        .PM_FUSE_BIT(fuse_bit), .OSC_IN_PIN(osc_in), .OSC_AMPL_OK(ampl_ok), .OSC_OUT_PIN_O(osc_o),
        .OSC_OUT_PIN_OE(osc_oe), .MASTER_RESET_N(master_reset_n_n), .WAKE_EVENT(wake), .CORE_RESET_N(core_n));
    osrt_osc_model u_osc (.clk(sys_clk), .run(osc_run), .code(code), .pm_addr(pm_addr), .pm_rd(pm_rd),
        .fuse_bit(fuse_bit), .osc(osc_in), .ampl_ok(ampl_ok));
    ////////////////////////////////////////////////////////////////
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_rng(input string what, input int lo, input int hi, input int got);
        checks++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("mismatch %s expected %0d to %0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic wait_core(output int cyc);
        cyc = 0;
        while (core_n !== 1'b1 && cyc < 9000) begin
            @(negedge sys_clk);
            cyc++;
        end
        @(posedge sys_clk);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_mismatch++;
        $display("mismatch watchdog expected end seen timeout");
        finish_test();
    end
    initial begin
        for (int m = 0; m < 4; m++) begin
            rstn <= 1'b0;
            master_reset_n_n <= 1'b0;
            osc_run <= 1'b0;
            code <= mcodes[m];
            xtal = !mcodes[m][0];
            repeat (8) @(posedge sys_clk);
            cmp("core in power-on reset", 32'h0000_0000, 32'(core_n));
            rstn <= 1'b1;
            if (m == 0) begin
                ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
                cmp("ctrl reset", 32'h0000_0001, rd);
                ahb(1'b1, 32'h0000_0000, 32'h0000_0000);
                ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
                cmp("ctrl written", 32'h0000_0000, rd);
                ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
                ahb(1'b0, 32'h0000_0010, 32'h0000_0000);
                cmp("unmapped read", 32'h0000_0000, rd);
            end
            repeat (50) @(posedge sys_clk);
            cmp("core under master reset", 32'h0000_0000, 32'(core_n));
            master_reset_n_n <= 1'b1;
            osc_run <= 1'b1;
            wait_core(n);
            cmp_rng("power-up hold", xtal ? 6340 : 4090, xtal ? 6380 : 4115, n);
            ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
            cmp("status", 32'h0000_0060 | 32'(mcodes[m]), rd);
            cmp("second pin drive", 32'(!xtal), 32'(osc_oe));
            q = 0;
            qo = osc_o;
            repeat (240) begin
                @(negedge sys_clk);
                q += 32'(osc_o !== qo);
                qo = osc_o;
            end
            cmp_rng("quarter clock toggles", xtal ? 0 : 19, xtal ? 0 : 21, q);
            @(posedge sys_clk);
            if (xtal) begin
                osc_run <= 1'b0;
                repeat (20) @(posedge sys_clk);
            end
            osc_run <= 1'b1;
            wake <= 1'b1;
            @(posedge sys_clk);
            wake <= 1'b0;
            @(negedge sys_clk);
            cmp("core after wake", 32'(!xtal), 32'(core_n));
            wait_core(n);
            cmp_rng("wake hold", xtal ? 6330 : 0, xtal ? 6380 : 0, n);
            $display("test mode %0d done", mcodes[m]);
        end
        finish_test();
    end
endmodule // osrt_top_bench
